// File: phy_cnt_params.svh
`ifndef PHY_CNT_PARAMS_SVH
`define PHY_CNT_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_FALSE_CARRIER  8'h14
`define IDX_RX_ERR         8'h15
`define IDX_PCS_CFG        8'h16
`define IDX_IRQ_STATUS     8'h20
`define IDX_IRQ_ENABLE     8'h21
`define IDX_IRQ_CLEAR      8'h22

// pcs_config_status fields
`define PCS_BLOCK_CODE_BYP 12
`define PCS_FREE_RX_CLK    11
`define PCS_QUIET_TX       10
`define PCS_SD_FORCE       9
`define PCS_SD_ALGO        8
`define PCS_FORCE_100_OK   5
`define PCS_NRZI_BYP       2
`define PCS_SCRAM_BYP      1
`define PCS_DESCRAM_BYP    0
`define PCS_WR_MASK        16'h1F27
`define PCS_RESET          16'h0100

`define CNT_RESET          8'h00
`define CNT_MAX            8'hFF

// interrupt status bits
`define IRQ_FC_EVENT       0
`define IRQ_RE_EVENT       1
`define IRQ_FC_SAT         2
`define IRQ_RE_SAT         3
`define IRQ_BITS           4

`endif

// File: phy_cnt_pkg.sv
package phy_cnt_pkg;
	typedef struct packed {
		logic block_code_bypass;
		logic rx_clk_free_run;
		logic quiet_transmit_enable;
		logic signal_detect_force;
		logic signal_detect_algorithm_select;
		logic force_100_link_ok;
		logic nrzi_bypass;
		logic tx_scrambler_bypass;
		logic rx_descrambler_bypass;
	} pcs_ctrl_s;

	typedef struct packed {
		logic false_carrier;
		logic rx_symbol_error;
		logic carrier_valid;
		logic collision;
	} rx_event_s;
endpackage

// File: phy_error_counters_pcs_config.sv
`timescale 1ns/1ns
`include "phy_cnt_params.svh"

module phy_error_counters_pcs_config
	import phy_cnt_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire rx_event_s   i_rx_event,
	output pcs_ctrl_s        o_pcs_ctrl,
	output logic             o_irq
);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic            acc;
	logic            wr;
	logic            rd;
	logic [9:0]      idx;
	logic            sel_fc;
	logic            sel_re;
	logic            sel_pcs;
	logic            sel_sts;
	logic            sel_en;
	logic            sel_clr;
	logic            mapped;

	assign acc     = i_psel && i_penable;
	assign wr      = acc && i_pwrite;
	assign rd      = acc && !i_pwrite;
	assign idx     = i_paddr[11:2];
	assign sel_fc  = (idx == 10'(`IDX_FALSE_CARRIER));
	assign sel_re  = (idx == 10'(`IDX_RX_ERR));
	assign sel_pcs = (idx == 10'(`IDX_PCS_CFG));
	assign sel_sts = (idx == 10'(`IDX_IRQ_STATUS));
	assign sel_en  = (idx == 10'(`IDX_IRQ_ENABLE));
	assign sel_clr = (idx == 10'(`IDX_IRQ_CLEAR));
	assign mapped  = sel_fc | sel_re | sel_pcs | sel_sts | sel_en | sel_clr;
	// single-cycle access phase keeps the counters' read-clear timing simple
	assign o_pready  = 1'b1;
	assign o_pslverr = acc && (!mapped || (i_paddr[1:0] != 2'h0));

	// ----------------------------------------
	// event qualification
	// ----------------------------------------
	logic            err_seen_q;
	logic            fc_evt;
	logic            re_evt;

	// one credit per carrier; a collision spends it without counting
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			err_seen_q <= 1'b0;
		end else begin
			if (!i_rx_event.carrier_valid)
				err_seen_q <= 1'b0;
			else if (i_rx_event.rx_symbol_error || i_rx_event.collision)
				err_seen_q <= 1'b1;
		end
	end

	assign fc_evt = i_rx_event.false_carrier;
	assign re_evt = i_rx_event.carrier_valid && i_rx_event.rx_symbol_error
		&& !i_rx_event.collision && !err_seen_q;

	// ----------------------------------------
	// counters
	// ----------------------------------------
	logic [CNT_W-1:0] fc_q;
	logic [CNT_W-1:0] re_q;
	logic [CNT_W-1:0] fc_d;
	logic [CNT_W-1:0] re_d;
	logic             fc_rd;
	logic             re_rd;

	assign fc_rd = rd && sel_fc;
	assign re_rd = rd && sel_re;

	always_comb begin
		fc_d = fc_q;
		if (wr && sel_fc)
			fc_d = i_pwdata[CNT_W-1:0];
		else if (fc_rd)
			// the snapshot left with the setup cycle; whatever counted since survives
			fc_d = (fc_q - o_prdata[CNT_W-1:0]) + CNT_W'(fc_evt);
		else if (fc_evt && fc_q != {CNT_W{1'b1}})
			fc_d = fc_q + 1'b1;
	end

	always_comb begin
		re_d = re_q;
		if (wr && sel_re)
			re_d = i_pwdata[CNT_W-1:0];
		else if (re_rd)
			re_d = (re_q - o_prdata[CNT_W-1:0]) + CNT_W'(re_evt);
		else if (re_evt && re_q != {CNT_W{1'b1}})
			re_d = re_q + 1'b1;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			fc_q <= CNT_W'(`CNT_RESET);
			re_q <= CNT_W'(`CNT_RESET);
		end else begin
			fc_q <= fc_d;
			re_q <= re_d;
		end
	end

	// ----------------------------------------
	// pcs configuration
	// ----------------------------------------
	logic [15:0] pcs_q;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			pcs_q <= `PCS_RESET;
		else if (wr && sel_pcs)
			pcs_q <= i_pwdata[15:0] & `PCS_WR_MASK;
	end

	always_comb begin
		o_pcs_ctrl.block_code_bypass              = pcs_q[`PCS_BLOCK_CODE_BYP];
		o_pcs_ctrl.rx_clk_free_run                = pcs_q[`PCS_FREE_RX_CLK];
		o_pcs_ctrl.quiet_transmit_enable          = pcs_q[`PCS_QUIET_TX];
		o_pcs_ctrl.signal_detect_force            = pcs_q[`PCS_SD_FORCE];
		o_pcs_ctrl.signal_detect_algorithm_select = pcs_q[`PCS_SD_ALGO];
		o_pcs_ctrl.force_100_link_ok              = pcs_q[`PCS_FORCE_100_OK];
		o_pcs_ctrl.nrzi_bypass                    = pcs_q[`PCS_NRZI_BYP];
		o_pcs_ctrl.tx_scrambler_bypass            = pcs_q[`PCS_SCRAM_BYP];
		o_pcs_ctrl.rx_descrambler_bypass          = pcs_q[`PCS_DESCRAM_BYP];
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic [`IRQ_BITS-1:0] sts_q;
	logic [`IRQ_BITS-1:0] en_q;
	logic [`IRQ_BITS-1:0] set_v;
	logic [`IRQ_BITS-1:0] clr_v;

	// saturation flags when an event carries the tally to the top or meets a write of FFh, not on a write alone
	assign set_v = {re_evt && re_d == {CNT_W{1'b1}} && re_q != {CNT_W{1'b1}},
		fc_evt && fc_d == {CNT_W{1'b1}} && fc_q != {CNT_W{1'b1}}, re_evt, fc_evt};
	assign clr_v = (wr && sel_clr) ? i_pwdata[`IRQ_BITS-1:0] : '0;

	// set wins over a same-cycle clear
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			sts_q <= '0;
		else
			sts_q <= (sts_q & ~clr_v) | set_v;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			en_q <= '0;
		else if (wr && sel_en)
			en_q <= i_pwdata[`IRQ_BITS-1:0];
	end

	assign o_irq = |(sts_q & en_q);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			o_prdata <= 32'h0000_0000;
		else if (i_psel && !i_penable && !i_pwrite) begin
			o_prdata <= 32'h0000_0000;
			if (sel_fc)
				o_prdata[CNT_W-1:0] <= fc_q;
			else if (sel_re)
				o_prdata[CNT_W-1:0] <= re_q;
			else if (sel_pcs)
				o_prdata[15:0] <= pcs_q;
			else if (sel_sts)
				o_prdata[`IRQ_BITS-1:0] <= sts_q;
			else if (sel_en)
				o_prdata[`IRQ_BITS-1:0] <= en_q;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_fc_sat;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(fc_q == 8'hFF && !(acc && sel_fc)) |=> fc_q == 8'hFF;
	endproperty
	a_fc_sat: assert property (p_fc_sat) else $error("false carrier tally left FFh");

	property p_fc_inc;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(fc_evt && !(acc && sel_fc) && fc_q != 8'hFF) |=> fc_q == $past(fc_q) + 8'h01;
	endproperty
	a_fc_inc: assert property (p_fc_inc) else $error("false carrier tally missed an event");

	property p_fc_cor;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(fc_rd && !fc_evt && !$past(fc_evt)) |=> fc_q == 8'h00;
	endproperty
	a_fc_cor: assert property (p_fc_cor) else $error("false carrier tally not cleared by read");

	property p_fc_cor_late;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(i_psel && !i_penable && !i_pwrite && sel_fc && fc_evt && fc_q != 8'hFF)
			##1 (fc_rd && !fc_evt) |=> fc_q == 8'h01;
	endproperty
	a_fc_cor_late: assert property (p_fc_cor_late) else $error("event before clearing read lost");

	property p_re_once;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(re_evt && i_rx_event.carrier_valid) ##1 i_rx_event.carrier_valid |-> !re_evt;
	endproperty
	a_re_once: assert property (p_re_once) else $error("receive error counted twice in one carrier");

	property p_re_col;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(i_rx_event.carrier_valid && i_rx_event.collision) ##1 i_rx_event.carrier_valid |-> !re_evt;
	endproperty
	a_re_col: assert property (p_re_col) else $error("receive error counted during collision");

	property p_re_sat;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(re_q == 8'hFF && !(acc && sel_re)) |=> re_q == 8'hFF;
	endproperty
	a_re_sat: assert property (p_re_sat) else $error("receive error tally left maximum");

	property p_rd_upper;
		@(posedge i_core_clk) disable iff (!i_resetn)
		$past(i_psel && !i_penable && !i_pwrite && (sel_fc || sel_re)) |-> o_prdata[31:8] == 24'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("counter upper byte not zero");

	property p_rd_clr_evt;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(re_rd && re_evt && !(wr && sel_re)) |=> re_q == 8'h01;
	endproperty
	a_rd_clr_evt: assert property (p_rd_clr_evt) else $error("event lost during clearing read");

	property p_re_cor;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(re_rd && !re_evt && !$past(re_evt)) |=> re_q == 8'h00;
	endproperty
	a_re_cor: assert property (p_re_cor) else $error("receive error tally not cleared by read");

	property p_re_cor_late;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(i_psel && !i_penable && !i_pwrite && sel_re && re_evt && re_q != 8'hFF)
			##1 (re_rd && !re_evt) |=> re_q == 8'h01;
	endproperty
	a_re_cor_late: assert property (p_re_cor_late) else $error("error before clearing read lost");

	property p_re_inc;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(re_evt && !(acc && sel_re) && re_q != 8'hFF) |=> re_q == $past(re_q) + 8'h01;
	endproperty
	a_re_inc: assert property (p_re_inc) else $error("receive error tally missed an event");

	property p_fc_wr;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(wr && sel_fc) |=> fc_q == $past(i_pwdata[7:0]);
	endproperty
	a_fc_wr: assert property (p_fc_wr) else $error("false carrier tally write not taken");

	property p_re_wr;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(wr && sel_re) |=> re_q == $past(i_pwdata[7:0]);
	endproperty
	a_re_wr: assert property (p_re_wr) else $error("receive error tally write not taken");

	property p_pcs_map;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(wr && sel_pcs) |=> o_pcs_ctrl.block_code_bypass == $past(i_pwdata[12])
			&& o_pcs_ctrl.signal_detect_algorithm_select == $past(i_pwdata[8]);
	endproperty
	a_pcs_map: assert property (p_pcs_map) else $error("pcs bits not applied");

	property p_pcs_map2;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(wr && sel_pcs) |=> o_pcs_ctrl.rx_clk_free_run == $past(i_pwdata[11])
			&& o_pcs_ctrl.quiet_transmit_enable == $past(i_pwdata[10])
			&& o_pcs_ctrl.signal_detect_force == $past(i_pwdata[9])
			&& o_pcs_ctrl.force_100_link_ok == $past(i_pwdata[5]);
	endproperty
	a_pcs_map2: assert property (p_pcs_map2) else $error("pcs mode bits lost");

	property p_pcs_map3;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(wr && sel_pcs) |=> o_pcs_ctrl.nrzi_bypass == $past(i_pwdata[2])
			&& o_pcs_ctrl.tx_scrambler_bypass == $past(i_pwdata[1])
			&& o_pcs_ctrl.rx_descrambler_bypass == $past(i_pwdata[0]);
	endproperty
	a_pcs_map3: assert property (p_pcs_map3) else $error("pcs coding bits lost");

	property p_pcs_hold;
		@(posedge i_core_clk) disable iff (!i_resetn)
		!(wr && sel_pcs) |=> $stable(o_pcs_ctrl);
	endproperty
	a_pcs_hold: assert property (p_pcs_hold) else $error("pcs controls moved without write");

	property p_sts_hold;
		@(posedge i_core_clk) disable iff (!i_resetn)
		1'b1 |=> ($past(sts_q & ~clr_v) & ~sts_q) == {`IRQ_BITS{1'b0}};
	endproperty
	a_sts_hold: assert property (p_sts_hold) else $error("status bit dropped without a clear");

	property p_fc_sat_irq;
		@(posedge i_core_clk) disable iff (!i_resetn)
		(fc_evt && fc_q == 8'hFE && !(acc && sel_fc)) |=> sts_q[`IRQ_FC_SAT];
	endproperty
	a_fc_sat_irq: assert property (p_fc_sat_irq) else $error("saturation not flagged");

	c_fc_sat: cover property (@(posedge i_core_clk) fc_q == 8'hFF);
	c_re_cor: cover property (@(posedge i_core_clk) re_rd && re_q != 8'h00);
	c_col: cover property (@(posedge i_core_clk) i_rx_event.collision
		&& i_rx_event.rx_symbol_error && i_rx_event.carrier_valid);
	c_irq: cover property (@(posedge i_core_clk) o_irq);
	c_rd_late: cover property (@(posedge i_core_clk) fc_rd && fc_q != o_prdata[CNT_W-1:0]);

endmodule

// File: tb_top.sv
`timescale 1ns/1ns
`include "phy_cnt_params.svh"

module tb_top
	import phy_cnt_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	rx_event_s   ev;
	pcs_ctrl_s   pcs;
	logic [31:0] rdv;
	logic        errv;
	int          n_errors;
	int          check_count;
	int          bit_pos [9] = '{12, 11, 10, 9, 8, 5, 2, 1, 0};

	phy_error_counters_pcs_config dut (
		.i_core_clk (clk),
		.i_resetn   (resetn),
		.i_psel     (psel),
		.i_penable  (penable),
		.i_pwrite   (pwrite),
		.i_paddr    (paddr),
		.i_pwdata   (pwdata),
		.o_prdata   (prdata),
		.o_pready   (pready),
		.o_pslverr  (pslverr),
		.i_rx_event (ev),
		.o_pcs_ctrl (pcs),
		.o_irq      (irq)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask

	// one apb transfer; waits for pready without assuming a latency
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_errors++;
			test_done();
		end else begin
			rdv = prdata;
			errv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
		xfer(1'b0, idx, 32'h0);
		chk(nm, rdv, exp);
	endtask

	// event pattern {false_carrier, symbol_error, carrier_valid, collision} for n edges
	task automatic drv(input logic [3:0] v, input int n);
		ev <= v;
		repeat (n) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ev = '0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(`IDX_FALSE_CARRIER, 32'h0, "fc_reset");
		rd(`IDX_RX_ERR, 32'h0, "re_reset");
		rd(`IDX_PCS_CFG, 32'h100, "pcs_reset");
		chk("pcs_out_reset", {23'h0, pcs}, 32'h10);
		$display("test reset done");

		for (int k = 0; k < 9; k++) begin
			xfer(1'b1, `IDX_PCS_CFG, 32'h1 << bit_pos[k]);
			rd(`IDX_PCS_CFG, 32'h1 << bit_pos[k], "pcs_rd");
			@(negedge clk);
			chk("pcs_out", {23'h0, pcs}, 32'h1 << (8 - k));
		end
		xfer(1'b1, `IDX_PCS_CFG, 32'hFFFF);
		rd(`IDX_PCS_CFG, 32'h1F27, "pcs_reserved");
		$display("test pcs done");

		drv(4'b1000, 3);
		drv(4'b0000, 1);
		rd(`IDX_FALSE_CARRIER, 32'h3, "fc_count");
		rd(`IDX_FALSE_CARRIER, 32'h0, "fc_cleared");
		xfer(1'b1, `IDX_FALSE_CARRIER, 32'hFFFF);
		rd(`IDX_FALSE_CARRIER, 32'hFF, "fc_upper");
		xfer(1'b1, `IDX_FALSE_CARRIER, 32'hFE);
		drv(4'b1000, 5);
		drv(4'b0000, 1);
		rd(`IDX_FALSE_CARRIER, 32'hFF, "fc_stick");
		$display("test false carrier done");

		drv(4'b0110, 1);
		drv(4'b0010, 1);
		drv(4'b0110, 2);
		drv(4'b0000, 2);
		drv(4'b0111, 2);
		drv(4'b0110, 2);
		drv(4'b0000, 2);
		rd(`IDX_RX_ERR, 32'h1, "re_once");
		xfer(1'b1, `IDX_RX_ERR, 32'hFFFF);
		drv(4'b0110, 2);
		drv(4'b0000, 2);
		rd(`IDX_RX_ERR, 32'hFF, "re_stick");
		rd(`IDX_RX_ERR, 32'h0, "re_cleared");
		$display("test receive error done");

		// d = 0 puts the event on the setup edge, d = 1 on the access edge
		for (int d = 0; d < 2; d++) begin
			xfer(1'b1, `IDX_FALSE_CARRIER, 32'h2);
			fork
				xfer(1'b0, `IDX_FALSE_CARRIER, 32'h0);
				begin
					repeat (d + 1) @(posedge clk);
					ev <= 4'b1000;
					@(posedge clk);
					ev <= 4'b0000;
				end
			join
			chk("fc_race_rd", rdv, 32'h2);
			rd(`IDX_FALSE_CARRIER, 32'h1, "fc_race_kept");
		end
		$display("test clear race done");

		xfer(1'b1, `IDX_IRQ_CLEAR, 32'hF);
		rd(`IDX_IRQ_STATUS, 32'h0, "irq_cleared");
		xfer(1'b1, `IDX_IRQ_ENABLE, 32'h1);
		drv(4'b1000, 1);
		drv(4'b0000, 1);
		@(negedge clk);
		chk("irq_raised", {31'h0, irq}, 32'h1);
		rd(`IDX_IRQ_STATUS, 32'h1, "irq_status");
		xfer(1'b1, `IDX_IRQ_ENABLE, 32'h0);
		@(negedge clk);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, `IDX_IRQ_ENABLE, 32'h1);
		xfer(1'b1, `IDX_IRQ_CLEAR, 32'h1);
		@(negedge clk);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		rd(`IDX_IRQ_CLEAR, 32'h0, "clr_reads_zero");
		chk("mapped_err", {31'h0, errv}, 32'h0);
		xfer(1'b1, `IDX_IRQ_CLEAR, 32'hF);
		xfer(1'b1, `IDX_FALSE_CARRIER, 32'hFE);
		xfer(1'b1, `IDX_RX_ERR, 32'hFE);
		drv(4'b1000, 1);
		drv(4'b0110, 1);
		drv(4'b0000, 1);
		rd(`IDX_IRQ_STATUS, 32'hF, "irq_sat_status");
		rd(`IDX_RX_ERR, 32'hFF, "re_reach_max");
		rd(`IDX_IRQ_ENABLE, 32'h1, "irq_enable_rd");
		$display("test irq done");

		xfer(1'b1, 8'h40, 32'hFFFF);
		chk("unmapped_wr_err", {31'h0, errv}, 32'h1);
		rd(8'h40, 32'h0, "unmapped_rd");
		chk("unmapped_rd_err", {31'h0, errv}, 32'h1);
		$display("test unmapped done");
		test_done();
	end
endmodule
